// File: src/dma_evt_pkg.sv
// Package: register map, field positions and reset values of the DMA
// channel event and interrupt control block.
// Assumes a 32-bit register port with word addresses held in a byte offset.
package dma_evt_pkg;
    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    localparam logic [7:0] OFS_EVENT_CTRL = 8'h00;
    localparam logic [7:0] OFS_INT_CTRL   = 8'h04;
    localparam logic [7:0] OFS_CHAN_CTRL  = 8'h08;
    localparam logic [7:0] OFS_PROGRESS   = 8'h0c;

    // ****************************************************************
    // Event control fields.
    // ****************************************************************
    localparam int ABORT_SEL_LSB  = 16;
    localparam int START_SEL_LSB  = 8;
    localparam int FORCE_BIT      = 7;
    localparam int ABORT_CMD_BIT  = 6;
    localparam int PAT_EN_BIT     = 5;
    localparam int START_EN_BIT   = 4;
    localparam int ABORT_EN_BIT   = 3;
    localparam logic [7:0] SEL_RESET = 8'hff;

    // ****************************************************************
    // Interrupt control fields: enables in 23:16, flags in 7:0.
    // ****************************************************************
    localparam int IE_LSB          = 16;
    localparam int EV_SRC_DONE     = 7;
    localparam int EV_SRC_HALF     = 6;
    localparam int EV_DST_DONE     = 5;
    localparam int EV_DST_HALF     = 4;
    localparam int EV_BLOCK_DONE   = 3;
    localparam int EV_CELL_DONE    = 2;
    localparam int EV_XFER_ABORT   = 1;
    localparam int EV_ADDR_ERROR   = 0;

    // Channel control register: channel_on in bit 7.
    localparam int CHAN_ON_BIT = 7;
endpackage : dma_evt_pkg

// File: src/dma_channel_event_irq_control.sv
// Module: per-channel event and interrupt control of a DMA controller.
// Assumes the transfer engine reports pointer and count events as pulses
// and irq_lines carries the system interrupt request levels.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_event_irq_control (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // System interrupt request lines.
    input  wire logic [255:0] irq_lines,
    // Transfer engine progress.
    input  wire logic [15:0] source_pointer,
    input  wire logic [15:0] source_size,
    input  wire logic [15:0] destination_pointer,
    input  wire logic [15:0] destination_size,
    input  wire logic        cell_done_evt,
    input  wire logic        block_done_evt,
    input  wire logic        pattern_match,
    input  wire logic        addr_error_evt,
    // Commands to the transfer engine, and the channel interrupt request.
    output logic             xfer_start,
    output logic             xfer_abort,
    output logic             channel_on,
    output logic             chan_irq
);

    // ****************************************************************
    // Reset release.
    // ****************************************************************
    logic rst_meta_ff;
    logic rst_sync_ff;

    // Two stages release the asynchronous reset cleanly.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [7:0]  abort_irq_select_ff;
    logic [7:0]  start_irq_select_ff;
    logic        pattern_abort_enable_ff;
    logic        start_on_irq_enable_ff;
    logic        abort_on_irq_enable_ff;
    logic [7:0]  ie_ff;
    logic [7:0]  flag_ff;
    logic        channel_on_ff;
    logic        xfer_start_ff;
    logic        xfer_abort_ff;
    logic [31:0] rdata_ff;
    logic [15:0] src_ptr_ff;
    logic [15:0] dst_ptr_ff;

    // Address decode.
    wire wr_event = reg_wr && (reg_addr == dma_evt_pkg::OFS_EVENT_CTRL);
    wire wr_int   = reg_wr && (reg_addr == dma_evt_pkg::OFS_INT_CTRL);
    wire wr_chan  = reg_wr && (reg_addr == dma_evt_pkg::OFS_CHAN_CTRL);

    // Interrupt selection; an irq fires on its rising edge.
    logic [255:0] irq_prev_ff;
    wire  [255:0] irq_rise    = irq_lines & ~irq_prev_ff;
    wire          start_hit   = irq_rise[start_irq_select_ff];
    wire          abort_hit   = irq_rise[abort_irq_select_ff];
    wire          start_irq_go = start_hit && start_on_irq_enable_ff;
    wire          abort_irq_go = abort_hit && abort_on_irq_enable_ff;
    wire          force_go    = wr_event && reg_wdata[dma_evt_pkg::FORCE_BIT];
    wire          cmd_abort   = wr_event && reg_wdata[dma_evt_pkg::ABORT_CMD_BIT];
    wire          pat_go      = pattern_match && pattern_abort_enable_ff;
    wire          abort_any   = abort_irq_go || cmd_abort || pat_go;
    wire          start_any   = (start_irq_go || force_go) && !abort_any;

    // Pointer threshold crossings: equality reached this cycle only.
    wire src_done_hit = (source_pointer == source_size) &&
                        (src_ptr_ff != source_size);
    wire src_half_hit = (source_pointer == {1'b0, source_size[15:1]}) &&
                        (src_ptr_ff != {1'b0, source_size[15:1]});
    wire dst_done_hit = (destination_pointer == destination_size) &&
                        (dst_ptr_ff != destination_size);
    wire dst_half_hit = (destination_pointer == {1'b0, destination_size[15:1]}) &&
                        (dst_ptr_ff != {1'b0, destination_size[15:1]});

    // Hardware set vector in event order.
    wire [7:0] flag_set = {src_done_hit, src_half_hit, dst_done_hit, dst_half_hit,
                           block_done_evt || pattern_match,
                           cell_done_evt,
                           abort_irq_go,
                           addr_error_evt};

    // Flags clear on a written zero and hold on a written one; a hardware set
    // in the same cycle wins, so an event that lands on a clear is never lost.
    wire [7:0] nxt_flag;
    for (genvar g = 0; g < 8; g++) begin : g_flag
        // Each flag keeps its state unless software writes a zero into it.
        wire keep_bit = flag_ff[g] && !(wr_int && !reg_wdata[g]);
        assign nxt_flag[g] = flag_set[g] || keep_bit;
    end

    // Channel enable: software sets it, pattern abort clears it.
    wire nxt_channel_on = pat_go ? 1'b0 :
                          (wr_chan ? reg_wdata[dma_evt_pkg::CHAN_ON_BIT] : channel_on_ff);

    // Read multiplexer; unmapped offsets read zero.
    wire [31:0] event_word = {8'h00, abort_irq_select_ff, start_irq_select_ff,
                              2'b00, pattern_abort_enable_ff, start_on_irq_enable_ff,
                              abort_on_irq_enable_ff, 3'b000};
    wire [31:0] int_word   = {8'h00, ie_ff, 8'h00, flag_ff};
    wire [31:0] nxt_rdata  =
        !reg_rd ? 32'h0000_0000 :
        (reg_addr == dma_evt_pkg::OFS_EVENT_CTRL) ? event_word :
        (reg_addr == dma_evt_pkg::OFS_INT_CTRL)   ? int_word :
        (reg_addr == dma_evt_pkg::OFS_CHAN_CTRL)  ? {24'h000000, channel_on_ff, 7'h00} :
        (reg_addr == dma_evt_pkg::OFS_PROGRESS)   ? {dst_ptr_ff, src_ptr_ff} : 32'h0000_0000;

    // ****************************************************************
    // Event control register.
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            abort_irq_select_ff     <= dma_evt_pkg::SEL_RESET;
            start_irq_select_ff     <= dma_evt_pkg::SEL_RESET;
            pattern_abort_enable_ff <= 1'b0;
            start_on_irq_enable_ff  <= 1'b0;
            abort_on_irq_enable_ff  <= 1'b0;
        end else if (wr_event) begin
            abort_irq_select_ff     <= reg_wdata[dma_evt_pkg::ABORT_SEL_LSB +: 8];
            start_irq_select_ff     <= reg_wdata[dma_evt_pkg::START_SEL_LSB +: 8];
            pattern_abort_enable_ff <= reg_wdata[dma_evt_pkg::PAT_EN_BIT];
            start_on_irq_enable_ff  <= reg_wdata[dma_evt_pkg::START_EN_BIT];
            abort_on_irq_enable_ff  <= reg_wdata[dma_evt_pkg::ABORT_EN_BIT];
        end
    end

    // ****************************************************************
    // Interrupt control, channel enable, commands and read data.
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            ie_ff         <= 8'h00;
            flag_ff       <= 8'h00;
            channel_on_ff <= 1'b0;
            xfer_start_ff <= 1'b0;
            xfer_abort_ff <= 1'b0;
            rdata_ff      <= 32'h0000_0000;
        end else begin
            if (wr_int) begin
                ie_ff <= reg_wdata[dma_evt_pkg::IE_LSB +: 8];
            end
            flag_ff       <= nxt_flag;
            channel_on_ff <= nxt_channel_on;
            xfer_start_ff <= start_any;
            xfer_abort_ff <= abort_any;
            rdata_ff      <= nxt_rdata;
        end
    end

    // Previous values for edge and crossing detection.
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            irq_prev_ff <= '0;
            src_ptr_ff  <= 16'h0000;
            dst_ptr_ff  <= 16'h0000;
        end else begin
            irq_prev_ff <= irq_lines;
            src_ptr_ff  <= source_pointer;
            dst_ptr_ff  <= destination_pointer;
        end
    end

    // Outputs.
    assign reg_rdata  = rdata_ff;
    assign xfer_start = xfer_start_ff;
    assign xfer_abort = xfer_abort_ff;
    assign channel_on = channel_on_ff;
    assign chan_irq   = |(flag_ff & ie_ff);

    // ****************************************************************
    // Checks.
    // ****************************************************************
    // The selected abort irq seen with its enable set.
    sequence s_abort_irq;
        abort_hit && abort_on_irq_enable_ff;
    endsequence

    // A start pulse that drops again unless a fresh start was asked for.
    sequence s_start_pulse;
        xfer_start ##1 (!xfer_start || $past(start_any));
    endsequence

    // Irq-driven start and abort, each behind its own enable.
    a_abort_irq_action: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        s_abort_irq |=> xfer_abort && flag_ff[dma_evt_pkg::EV_XFER_ABORT])
        else $error("Abort irq did not abort and flag.");
    a_abort_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (abort_hit && !abort_on_irq_enable_ff && !cmd_abort && !pat_go) |=> !xfer_abort)
        else $error("Disabled abort irq aborted.");
    a_start_irq_go: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (start_hit && start_on_irq_enable_ff && !abort_any) |=> xfer_start)
        else $error("Start irq did not start.");
    a_start_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (!start_on_irq_enable_ff && !force_go) |=> !xfer_start)
        else $error("Start without a cause.");

    // Software commands act for one cycle, and an abort suppresses a start.
    a_force_start: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (force_go && !abort_any) |=> s_start_pulse)
        else $error("Force did not start one pulse.");
    a_cmd_abort: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        cmd_abort |=> xfer_abort)
        else $error("Abort command ignored.");
    a_abort_wins: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        abort_any |=> !xfer_start)
        else $error("Start issued beside an abort.");
    a_abort_pulse: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (xfer_abort && !abort_any) |=> !xfer_abort)
        else $error("Abort pulse lasted too long.");

    // Pattern match aborts and stops the channel only while enabled.
    a_pattern_abort: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        pat_go |=> !channel_on && xfer_abort)
        else $error("Pattern abort failed.");
    a_pattern_ignored: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (pattern_match && !pattern_abort_enable_ff && !cmd_abort && !abort_irq_go && !wr_chan)
        |=> $stable(channel_on) && !xfer_abort)
        else $error("Disabled pattern match had an effect.");

    // ****************************************************************
    // Register read checks.
    // ****************************************************************
    // Unimplemented and command bits of the event word read zero.
    a_event_reads: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (reg_rd && reg_addr == dma_evt_pkg::OFS_EVENT_CTRL) |=>
        reg_rdata[31:24] == 8'h00 && reg_rdata[7:0] == {2'b00, $past(event_word[5:0])})
        else $error("Event control reserved bits not zero.");
    // Unused bits of the interrupt word read zero.
    a_int_reads: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (reg_rd && reg_addr == dma_evt_pkg::OFS_INT_CTRL) |=>
        reg_rdata[31:24] == 8'h00 && reg_rdata[15:8] == 8'h00)
        else $error("Interrupt control unused bits not zero.");

    // ****************************************************************
    // Event flag checks.
    // ****************************************************************
    // Source pointer newly meeting its size while the size holds still.
    sequence s_src_done_cross;
        (source_pointer != source_size) ##1
        ((source_pointer == source_size) && $stable(source_size));
    endsequence
    // Source pointer newly meeting half its size.
    sequence s_src_half_cross;
        (source_pointer != (source_size >> 1)) ##1
        ((source_pointer == (source_size >> 1)) && $stable(source_size));
    endsequence
    // Destination pointer newly meeting its size.
    sequence s_dst_done_cross;
        (destination_pointer != destination_size) ##1
        ((destination_pointer == destination_size) && $stable(destination_size));
    endsequence
    // Destination pointer newly meeting half its size.
    sequence s_dst_half_cross;
        (destination_pointer != (destination_size >> 1)) ##1
        ((destination_pointer == (destination_size >> 1)) && $stable(destination_size));
    endsequence

    // Each pointer crossing raises its own flag one cycle later.
    a_src_done_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        s_src_done_cross |=> flag_ff[dma_evt_pkg::EV_SRC_DONE])
        else $error("Source done flag not set.");
    a_src_half_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        s_src_half_cross |=> flag_ff[dma_evt_pkg::EV_SRC_HALF])
        else $error("Source half flag not set.");
    a_dst_done_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        s_dst_done_cross |=> flag_ff[dma_evt_pkg::EV_DST_DONE])
        else $error("Destination done flag not set.");
    a_dst_half_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        s_dst_half_cross |=> flag_ff[dma_evt_pkg::EV_DST_HALF])
        else $error("Destination half flag not set.");

    // Engine pulses raise the block and cell flags.
    a_block_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (block_done_evt || pattern_match) |=> flag_ff[dma_evt_pkg::EV_BLOCK_DONE])
        else $error("Block flag not set.");
    a_cell_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        cell_done_evt |=> flag_ff[dma_evt_pkg::EV_CELL_DONE])
        else $error("Cell flag not set.");

    // Flags hold against a clear that meets a set, and a written zero clears.
    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (flag_set != 8'h00) |=> (flag_ff & $past(flag_set)) == $past(flag_set))
        else $error("Hardware set lost.");
    a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (wr_int && flag_set == 8'h00) |=> flag_ff == ($past(flag_ff) & $past(reg_wdata[7:0])))
        else $error("Flag write did not clear or keep.");

    // The request output follows the enabled flags.
    a_irq_output: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (wr_int && reg_wdata[7:0] == 8'h00 && flag_set == 8'h00) |=> !chan_irq)
        else $error("Irq stayed up after clearing.");
    a_irq_raise: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        (abort_irq_go && ie_ff[dma_evt_pkg::EV_XFER_ABORT] && !wr_int) |=> chan_irq)
        else $error("Enabled flag did not raise irq.");
endmodule : dma_channel_event_irq_control
`default_nettype wire

// File: tb/dma_far_side.sv
// Far-side model: the system interrupt lines and the channel's transfer engine.
// Assumes the bench calls its tasks just after a rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module dma_far_side (
    // Clock.
    input  wire logic         ref_clk,
    // Commands from the channel.
    input  wire logic         xfer_start,
    input  wire logic         xfer_abort,
    // Interrupt levels and engine progress.
    output logic      [255:0] irq_lines,
    output logic      [15:0]  source_pointer,
    output logic      [15:0]  destination_pointer,
    output logic      [3:0]   engine_evt
);
    int n_start = 0;
    int n_abort = 0;
    // Everything idles low until the bench asks for activity.
    initial begin
        irq_lines = '0;
        source_pointer = 16'h0000;
        destination_pointer = 16'h0000;
        engine_evt = 4'h0;
    end
    // The engine counts every command pulse it is handed.
    always @(posedge ref_clk) begin
        n_start <= n_start + int'(xfer_start);
        n_abort <= n_abort + int'(xfer_abort);
    end
    // One occurrence: a level that is high for a single cycle, then settle.
    task automatic fire(input int num);
        irq_lines[num] <= 1'h1;
        @(posedge ref_clk);
        irq_lines[num] <= 1'h0;
        repeat (3) @(posedge ref_clk);
    endtask : fire
    // Engine pulses: {pattern, block, cell, address error}.
    task automatic pulse(input logic [3:0] p);
        @(posedge ref_clk);
        engine_evt <= p;
        @(posedge ref_clk);
        engine_evt <= 4'h0;
        repeat (3) @(posedge ref_clk);
    endtask : pulse
    // Moves both pointers at once, as the engine advances.
    task automatic move(input logic [15:0] sp, input logic [15:0] dp);
        @(posedge ref_clk);
        source_pointer <= sp;
        destination_pointer <= dp;
        repeat (3) @(posedge ref_clk);
    endtask : move
endmodule : dma_far_side
`default_nettype wire

// File: tb/dma_channel_event_irq_control_tb.sv
// Testbench of the channel event and interrupt control block.
// Assumes dma_far_side plays the interrupt lines and the transfer engine.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_event_irq_control_tb;
    localparam logic [7:0]  EVC = dma_evt_pkg::OFS_EVENT_CTRL;
    localparam logic [7:0]  INC = dma_evt_pkg::OFS_INT_CTRL;
    logic [15:0]  src_size = 16'h0010;
    localparam logic [15:0] DST_SIZE = 16'h0020;
    logic         ref_clk = 1'h0;
    logic         rst_n = 1'h0;
    logic [7:0]   reg_addr = 8'h00;
    logic [31:0]  reg_wdata = 32'h0;
    logic         reg_wr = 1'h0;
    logic         reg_rd = 1'h0;
    wire  [31:0]  reg_rdata;
    wire  [255:0] irq_lines;
    wire  [15:0]  sp;
    wire  [15:0]  dp;
    wire  [3:0]   evt;
    wire          xfer_start, xfer_abort, channel_on, chan_irq;
    int n_fail = 0;
    int samples_checked = 0;
    int exp_start = 0;
    int exp_abort = 0;
    // Clock at 40 MHz.
    always #12.5 ref_clk = ~ref_clk;
    // Block under test and its far side.
    dma_channel_event_irq_control i_dma_channel_event_irq_control (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_lines(irq_lines),
        .source_pointer(sp), .source_size(src_size), .destination_pointer(dp),
        .destination_size(DST_SIZE), .cell_done_evt(evt[1]), .block_done_evt(evt[2]),
        .pattern_match(evt[3]), .addr_error_evt(evt[0]), .xfer_start(xfer_start),
        .xfer_abort(xfer_abort), .channel_on(channel_on), .chan_irq(chan_irq));
    dma_far_side i_dma_far_side (
        .ref_clk(ref_clk), .xfer_start(xfer_start), .xfer_abort(xfer_abort),
        .irq_lines(irq_lines), .source_pointer(sp), .destination_pointer(dp),
        .engine_evt(evt));
    // Counts and reports one comparison.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk
    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask : wr
    // One-cycle read; the data stand only in the following cycle.
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd_chk
    // Lets command pulses reach the engine, then compares its counts.
    task automatic chk_cmds();
        repeat (2) @(posedge ref_clk);
        chk("starts", exp_start, i_dma_far_side.n_start);
        chk("aborts", exp_abort, i_dma_far_side.n_abort);
    endtask : chk_cmds
    // Reset values, unused bits and an unmapped offset.
    task automatic t_regs();
        rd_chk("event reset", EVC, 32'h00ffff00);
        rd_chk("int reset", INC, 32'h00000000);
        rd_chk("unmapped", 8'h10, 32'h00000000);
        wr(EVC, 32'hffffff38);
        rd_chk("event bits", EVC, 32'h00ffff38);
        wr(INC, 32'hffffffff);
        rd_chk("int bits", INC, 32'h00ff0000);
        $display("test regs done");
    endtask : t_regs
    // Start and abort selection over low, next and top numbers, then disabled.
    task automatic t_irq();
        logic [7:0] s;
        for (int k = 0; k < 3; k++) begin
            s = (k == 2) ? 8'hff : 8'(k);
            wr(EVC, {8'h00, ~s, s, 8'h18});
            wr(INC, 32'h00ff0000);
            i_dma_far_side.fire(int'(s));
            exp_start++;
            chk_cmds();
            i_dma_far_side.fire(int'(~s));
            exp_abort++;
            chk_cmds();
            rd_chk("abort flag", INC, 32'h00ff0002);
            chk("irq on", 32'h1, {31'h0, chan_irq});
            wr(EVC, {8'h00, ~s, s, 8'h00});
            wr(INC, 32'h00ff0000);
            i_dma_far_side.fire(int'(s));
            i_dma_far_side.fire(int'(~s));
            chk_cmds();
            rd_chk("no flag", INC, 32'h00ff0000);
        end
        $display("test irq done");
    endtask : t_irq
    // Command bits act once and read back as zero.
    task automatic t_cmds();
        wr(EVC, 32'h00ffff80);
        exp_start++;
        chk_cmds();
        rd_chk("cmd bits", EVC, 32'h00ffff00);
        wr(EVC, 32'h00ffff40);
        exp_abort++;
        chk_cmds();
        wr(EVC, 32'h00ffffc0);
        exp_abort++;
        chk_cmds();
        $display("test cmds done");
    endtask : t_cmds
    // Pattern match with the abort enable set, then clear.
    task automatic t_pattern();
        wr(8'h08, 32'h00000080);
        wr(EVC, 32'h00ffff20);
        wr(INC, 32'h00ff0000);
        i_dma_far_side.pulse(4'h8);
        exp_abort++;
        chk_cmds();
        chk("chan off", 32'h0, {31'h0, channel_on});
        rd_chk("block flag", INC, 32'h00ff0008);
        wr(8'h08, 32'h00000080);
        wr(EVC, 32'h00ffff00);
        i_dma_far_side.pulse(4'h8);
        chk_cmds();
        chk("chan kept", 32'h1, {31'h0, channel_on});
        rd_chk("chan reg", 8'h08, 32'h00000080);
        $display("test pattern done");
    endtask : t_pattern
    // Pointer, engine flags, enable gating and clearing.
    task automatic t_flags();
        wr(INC, 32'h00ff0000);
        #1;
        chk("irq idle", 32'h0, {31'h0, chan_irq});
        i_dma_far_side.move(16'h0008, 16'h0000);
        rd_chk("src half", INC, 32'h00ff0040);
        chk("irq half", 32'h1, {31'h0, chan_irq});
        i_dma_far_side.move(16'h0010, 16'h0010);
        rd_chk("src done", INC, 32'h00ff00d0);
        i_dma_far_side.move(16'h0010, 16'h0020);
        rd_chk("dst done", INC, 32'h00ff00f0);
        rd_chk("progress", 8'h0c, 32'h00200010);
        i_dma_far_side.pulse(4'h7);
        rd_chk("engine", INC, 32'h00ff00fd);
        wr(INC, 32'h000000fd);
        rd_chk("kept", INC, 32'h000000fd);
        chk("irq masked", 32'h0, {31'h0, chan_irq});
        wr(INC, 32'h00000000);
        rd_chk("cleared", INC, 32'h00000000);
        @(posedge ref_clk);
        src_size <= 16'h0030;
        i_dma_far_side.move(16'h0018, 16'h0020);
        rd_chk("new half", INC, 32'h00000040);
        i_dma_far_side.move(16'h0030, 16'h0020);
        rd_chk("new done", INC, 32'h000000c0);
        $display("test flags done");
    endtask : t_flags
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    // Reset, then the scenarios in turn.
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge ref_clk);
        t_regs();
        t_irq();
        t_cmds();
        t_pattern();
        t_flags();
        end_sim();
    end
endmodule : dma_channel_event_irq_control_tb
`default_nettype wire
